/* design/tws_cfg.svh */
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the clock generator and control design files
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// Register byte offsets
`define TWS_ADDR_CTRL     8'h00
`define TWS_ADDR_DATA     8'h04
`define TWS_ADDR_STAT     8'h08
`define TWS_ADDR_MASK     8'h0C
`define TWS_ADDR_PINS     8'h10

// Control register fields
`define TWS_CTRL_START    0
`define TWS_CTRL_CLKLO    1
`define TWS_CTRL_CLKHI    2
`define TWS_CTRL_SOEN     3
`define TWS_CTRL_SCKDIR   4
`define TWS_CTRL_SODIR    5
`define TWS_CTRL_SIDIR    6
`define TWS_CTRL_GPSCK    8
`define TWS_CTRL_GPSO     9
`define TWS_CTRL_GPSI     10

// Status and mask fields
`define TWS_STAT_DONE     0

// Values
`define TWS_LOST_VAL      8'hFF
`define TWS_SHIFT_RST     8'h00
`define TWS_LAST_CNT      4'h7
`define TWS_RD_ZERO       32'h0000_0000

// Timing
`define TWS_CLK_NS        100
`define TWS_SCK_HALF_NS   400
`define TWS_SCK_HALF_CYC  ((`TWS_SCK_HALF_NS) / (`TWS_CLK_NS))

`endif

/* design/tws_clkgen.sv */
// Internal shift clock generator, idles high
// Assumes run drops as soon as the transfer ends
`include "tws_cfg.svh"
module tws_clkgen #(
    parameter int HALF = `TWS_SCK_HALF_CYC
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic clkEn,
    // Carrier
    tws_sck_if.gen    sck
);
    logic [7:0] cnt_q;
    logic [7:0] lim;

    // Selection 2 doubles the half period, selection 3 quadruples it
    always_comb begin
        unique case (sck.sel)
            2'h2:    lim = 8'((HALF * 2) - 1);
            2'h3:    lim = 8'((HALF * 4) - 1);
            default: lim = 8'(HALF - 1);
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_q   <= 8'h00;
            sck.lvl <= 1'b1;
        end else if (clkEn) begin
            if (!sck.run) begin
                cnt_q   <= 8'h00;
                sck.lvl <= 1'b1;
            end else if (cnt_q >= lim) begin
                cnt_q   <= 8'h00;
                sck.lvl <= !sck.lvl;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

/* design/tws_ctrl.sv */
// Three-wire serial interface: wait control, bit counter, shift register
// Assumes an AHB-Lite master on core_clk and pins from another domain
//
// Contract
// - First bit on next falling edge; eight clocks
// - After eight clocks: clock high, all frozen
// - Read released with clock high loses data
// - Write released with clock low is lost
// - Writing start zero forces wait, clears counter
// - Interrupt on rising edge counter reaching eight
// - Master output pin high while waiting
// - One write releases and selects clock
// - Restart while released changes nothing
// - Wait write shows MSB after next release
// - Released high write shows MSB at once
// - Both selects zero: slave, else master
// - Counter counts rises, wraps, clears on stop
// - Out MSB on falling, in LSB rising
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`include "tws_cfg.svh"
module tws_ctrl #(
    parameter int HALF = `TWS_SCK_HALF_CYC
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Shift clock pin
    input  wire logic        sckPinIn,
    output logic             sckPinOut,
    output logic             sckPinOe,
    // Serial out pin
    input  wire logic        soutPinIn,
    output logic             soutPinOut,
    output logic             soutPinOe,
    // Serial in pin
    input  wire logic        sinPinIn,
    output logic             sinPinOut,
    output logic             sinPinOe,
    // Interrupt
    output logic             irq
);
    tws_sck_if sck ();

    tws_pkg::tws_bus_t busState_q;
    logic [7:0]  addr_q;
    logic        wr_q;
    logic [31:0] readMux;

    logic        xferStart_q;
    logic        clkSelLo_q;
    logic        clkSelHi_q;
    logic        serialOutEnable_q;
    logic        clkPinDir_q;
    logic        soutPinDir_q;
    logic        sinPinDir_q;
    logic        gpSck_q;
    logic        gpSo_q;
    logic        gpSi_q;
    logic        status_q;
    logic        mask_q;
    logic [3:0]  cnt_q;
    logic [7:0]  serialShiftReg_q;
    logic        soutBit_q;
    logic        sckPrev_q;
    logic [2:0]  pinSync;

    logic        busWr;
    logic        busRd;
    logic        ctrlWr;
    logic        dataWr;
    logic        dataRd;
    logic        statRd;
    logic        master;
    logic        running;
    logic        sckLvl;
    logic        sckRise;
    logic        sckFall;
    logic        doneEvt;
    logic        hotWindow;

    tws_sync #(
        .W   (3),
        .RST (3'b101)
    ) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .clkEn    (clkEn),
        .asyncIn  ({soutPinIn, sinPinIn, sckPinIn}),
        .syncOut  (pinSync)
    );

    tws_clkgen #(
        .HALF (HALF)
    ) u_clkgen (
        .core_clk (core_clk),
        .reset    (reset),
        .clkEn    (clkEn),
        .sck      (sck.gen)
    );

    // Bus data phase decode
    assign busWr   = (busState_q == tws_pkg::BUS_DATA) && wr_q;
    assign busRd   = (busState_q == tws_pkg::BUS_DATA) && !wr_q;
    assign ctrlWr  = busWr && (addr_q == `TWS_ADDR_CTRL);
    assign dataWr  = busWr && (addr_q == `TWS_ADDR_DATA);
    assign dataRd  = busRd && (addr_q == `TWS_ADDR_DATA);
    assign statRd  = busRd && (addr_q == `TWS_ADDR_STAT);

    // Shift clock source and edges
    assign master  = clkSelHi_q || clkSelLo_q;
    assign running = xferStart_q;
    assign sck.run = running && master;
    assign sck.sel = {clkSelHi_q, clkSelLo_q};
    // Counter reads the clock level, not the source
    assign sckLvl  = master ? sck.lvl : pinSync[0];
    assign sckRise = sckLvl && !sckPrev_q;
    assign sckFall = !sckLvl && sckPrev_q;
    assign doneEvt = running && sckRise && (cnt_q == `TWS_LAST_CNT);
    // Released with clock high: reads break, writes land
    assign hotWindow = running && sckLvl;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sckPrev_q <= 1'b1;
        end else if (clkEn) begin
            sckPrev_q <= sckLvl;
        end
    end

    // AHB-Lite slave: one wait state on every transfer
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busState_q <= tws_pkg::BUS_ADDR;
            addr_q     <= 8'h00;
            wr_q       <= 1'b0;
            hreadyout  <= 1'b1;
            hrdata     <= `TWS_RD_ZERO;
            hresp      <= 1'b0;
        end else if (clkEn) begin
            unique case (busState_q)
                tws_pkg::BUS_ADDR: begin
                    if (hsel && hready && htrans[1]) begin
                        addr_q     <= haddr[7:0];
                        wr_q       <= hwrite;
                        hreadyout  <= 1'b0;
                        busState_q <= tws_pkg::BUS_DATA;
                    end
                end
                tws_pkg::BUS_DATA: begin
                    hrdata     <= wr_q ? `TWS_RD_ZERO : readMux;
                    hreadyout  <= 1'b1;
                    busState_q <= tws_pkg::BUS_ADDR;
                end
            endcase
        end
    end

    always_comb begin
        readMux = `TWS_RD_ZERO;
        unique case (addr_q)
            `TWS_ADDR_CTRL: begin
                readMux[`TWS_CTRL_START]  = xferStart_q;
                readMux[`TWS_CTRL_CLKLO]  = clkSelLo_q;
                readMux[`TWS_CTRL_CLKHI]  = clkSelHi_q;
                readMux[`TWS_CTRL_SOEN]   = serialOutEnable_q;
                readMux[`TWS_CTRL_SCKDIR] = clkPinDir_q;
                readMux[`TWS_CTRL_SODIR]  = soutPinDir_q;
                readMux[`TWS_CTRL_SIDIR]  = sinPinDir_q;
                readMux[`TWS_CTRL_GPSCK]  = gpSck_q;
                readMux[`TWS_CTRL_GPSO]   = gpSo_q;
                readMux[`TWS_CTRL_GPSI]   = gpSi_q;
            end
            `TWS_ADDR_DATA:
                readMux[7:0] = hotWindow ? `TWS_LOST_VAL
                                         : serialShiftReg_q;
            `TWS_ADDR_STAT: readMux[`TWS_STAT_DONE] = status_q;
            `TWS_ADDR_MASK: readMux[`TWS_STAT_DONE] = mask_q;
            `TWS_ADDR_PINS: readMux[7:0] = {cnt_q, 1'b0, pinSync};
            default:        readMux = `TWS_RD_ZERO;
        endcase
    end

    // Control fields; start flag is the wait control
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            xferStart_q       <= 1'b0;
            clkSelLo_q        <= 1'b0;
            clkSelHi_q        <= 1'b0;
            serialOutEnable_q <= 1'b0;
            clkPinDir_q       <= 1'b0;
            soutPinDir_q      <= 1'b0;
            sinPinDir_q       <= 1'b0;
            gpSck_q           <= 1'b0;
            gpSo_q            <= 1'b0;
            gpSi_q            <= 1'b0;
        end else if (clkEn) begin
            if (ctrlWr) begin
                clkSelLo_q        <= hwdata[`TWS_CTRL_CLKLO];
                clkSelHi_q        <= hwdata[`TWS_CTRL_CLKHI];
                serialOutEnable_q <= hwdata[`TWS_CTRL_SOEN];
                clkPinDir_q       <= hwdata[`TWS_CTRL_SCKDIR];
                soutPinDir_q      <= hwdata[`TWS_CTRL_SODIR];
                sinPinDir_q       <= hwdata[`TWS_CTRL_SIDIR];
                gpSck_q           <= hwdata[`TWS_CTRL_GPSCK];
                gpSo_q            <= hwdata[`TWS_CTRL_GPSO];
                gpSi_q            <= hwdata[`TWS_CTRL_GPSI];
                if (!hwdata[`TWS_CTRL_START])
                    xferStart_q <= 1'b0;
                else if (!running)
                    xferStart_q <= 1'b1;
                else
                    xferStart_q <= !doneEvt;
            end else if (doneEvt) begin
                xferStart_q <= 1'b0;
            end
        end
    end

    // Bit counter, frozen while waiting
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 4'h0;
        end else if (clkEn) begin
            if (ctrlWr && !hwdata[`TWS_CTRL_START])
                cnt_q <= 4'h0;
            else if (running && sckRise)
                cnt_q <= doneEvt ? 4'h0 : cnt_q + 4'h1;
        end
    end

    // Shift register and its bus accesses
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            serialShiftReg_q <= `TWS_SHIFT_RST;
        end else if (clkEn) begin
            if (dataWr) begin
                // Write with clock low would race the shift
                if (!running || sckLvl)
                    serialShiftReg_q <= hwdata[7:0];
            end else if (dataRd && hotWindow) begin
                serialShiftReg_q <= `TWS_LOST_VAL;
            end else if (running && sckRise) begin
                serialShiftReg_q <= {serialShiftReg_q[6:0],
                                     pinSync[1]};
            end
        end
    end

    // Output bit changes only on falling edge or hot write
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            soutBit_q <= 1'b0;
        end else if (clkEn) begin
            if (dataWr && hotWindow)
                soutBit_q <= hwdata[7];
            else if (running && sckFall)
                soutBit_q <= serialShiftReg_q[7];
        end
    end

    // Sticky done flag, read clears, set wins
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status_q <= 1'b0;
            mask_q   <= 1'b0;
            irq      <= 1'b0;
        end else if (clkEn) begin
            if (doneEvt)
                status_q <= 1'b1;
            else if (statRd)
                status_q <= 1'b0;
            if (busWr && addr_q == `TWS_ADDR_MASK)
                mask_q <= hwdata[`TWS_STAT_DONE];
            irq <= status_q && mask_q;
        end
    end

    // Registered pin drivers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sckPinOut  <= 1'b0;
            sckPinOe   <= 1'b0;
            soutPinOut <= 1'b0;
            soutPinOe  <= 1'b0;
            sinPinOut  <= 1'b0;
            sinPinOe   <= 1'b0;
        end else if (clkEn) begin
            sckPinOe   <= clkPinDir_q;
            // Wait forces high while the generator still sits low
            sckPinOut  <= master ? (sck.lvl || !running)
                                 : gpSck_q;
            soutPinOe  <= soutPinDir_q;
            soutPinOut <= serialOutEnable_q ? soutBit_q : gpSo_q;
            sinPinOe   <= sinPinDir_q;
            sinPinOut  <= gpSi_q;
        end
    end

    wait_sck_high_a: assert property (
        @(posedge core_clk) disable iff (reset)
        clkEn && master && !running |=> sckPinOut)
        else $error("shift clock pin not high in wait");

    done_irq_a: assert property (
        @(posedge core_clk) disable iff (reset)
        clkEn && running && sckRise && cnt_q == 4'h7
        |=> status_q && !xferStart_q && cnt_q == 4'h0)
        else $error("eighth rise did not flag done");

    forced_wait_a: assert property (
        @(posedge core_clk) disable iff (reset)
        clkEn && ctrlWr && !hwdata[0] |=> !xferStart_q && cnt_q == 4'h0)
        else $error("forced wait not taken");

    restart_keep_a: assert property (
        @(posedge core_clk) disable iff (reset)
        clkEn && ctrlWr && hwdata[0] && running && !sckRise
        |=> xferStart_q && $stable(cnt_q))
        else $error("restart disturbed transfer");

    wait_freeze_a: assert property (
        @(posedge core_clk) disable iff (reset)
        clkEn && !running && !dataWr |=> $stable(serialShiftReg_q)
            && $stable(cnt_q))
        else $error("state moved during wait");

    lost_read_a: assert property (
        @(posedge core_clk) disable iff (reset)
        clkEn && dataRd && hotWindow
        |=> hrdata[7:0] == 8'hFF && serialShiftReg_q == 8'hFF)
        else $error("hot read not lost");

    bad_write_a: assert property (
        @(posedge core_clk) disable iff (reset)
        clkEn && dataWr && running && !sckLvl
        |=> $stable(serialShiftReg_q))
        else $error("low-clock write stored");

    hot_write_a: assert property (
        @(posedge core_clk) disable iff (reset)
        clkEn && dataWr && hotWindow && !sckRise
        |=> soutBit_q == $past(hwdata[7]) && $stable(cnt_q))
        else $error("hot write MSB not shown");

    msb_out_a: assert property (
        @(posedge core_clk) disable iff (reset)
        clkEn && running && sckFall && !dataWr
        |=> soutBit_q == $past(serialShiftReg_q[7]))
        else $error("MSB not shifted out");

    slave_mode_a: assert property (
        @(posedge core_clk) disable iff (reset)
        clkEn && !clkSelHi_q && !clkSelLo_q
        |-> !sck.run ##1 sckPinOut == $past(gpSck_q))
        else $error("slave mode runs internal clock");

    sout_pin_a: assert property (
        @(posedge core_clk) disable iff (reset)
        clkEn && serialOutEnable_q ##1 clkEn
        |-> soutPinOut == $past(soutBit_q))
        else $error("serial out pin not from shifter");
endmodule

/* design/tws_pkg.sv */
// Types shared by the serial block modules
// Assumes tws_cfg.svh holds all numeric constants
package tws_pkg;

    typedef enum logic {
        BUS_ADDR,
        BUS_DATA
    } tws_bus_t;

    typedef logic [1:0] tws_clksel_t;

endpackage

/* design/tws_sck_if.sv */
// Carrier between the control block and the shift clock generator
// Assumes one core clock domain on both sides
interface tws_sck_if;
    logic                 run;
    tws_pkg::tws_clksel_t sel;
    logic                 lvl;

    modport gen (input run, input sel, output lvl);
    modport ctl (output run, output sel, input lvl);
endinterface

/* design/tws_sync.sv */
// Two-stage synchroniser for a group of pin levels
// Assumes asynchronous inputs, one core clock
module tws_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic         clkEn,
    // Levels
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            // Idle pin levels, so no false edge follows reset
            meta_q  <= RST;
            syncOut <= RST;
        end else if (clkEn) begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

/* test/three_wire_serial_wait_ctrl_tb.sv */
// Self-checking bench for the serial block over its register bus
// Assumes tws_cfg.svh offsets and a 10 MHz core clock
`include "tws_cfg.svh"
module three_wire_serial_wait_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ST = 32'h1 << `TWS_CTRL_START;
    localparam logic [31:0] SO = (32'h1 << `TWS_CTRL_SOEN)
                               | (32'h1 << `TWS_CTRL_SODIR);
    localparam logic [31:0] CK = 32'h1 << `TWS_CTRL_SCKDIR;
    localparam logic [31:0] DIRS = CK | (32'h1 << `TWS_CTRL_SODIR)
                                 | (32'h1 << `TWS_CTRL_SIDIR);
    localparam logic [31:0] GP = 32'h7 << `TWS_CTRL_GPSCK;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd, ctl;
    logic        hreadyout, hresp, irq, arm = 1'b0, drvClk = 1'b0;
    logic        sckPinOut, sckPinOe, soutPinOut, soutPinOe;
    logic        sinPinOut, sinPinOe, pSck, pSckOe, pSin;
    logic [7:0]  pTx = 8'h00;
    logic [7:0]  rxByte;
    int          riseCnt, miscompares = 0, checked = 0;
    wire logic   sckWire = sckPinOe ? sckPinOut : (pSckOe ? pSck : 1'b1);
    wire logic   sinWire = sinPinOe ? sinPinOut : pSin;
    wire logic   soutWire = soutPinOe ? soutPinOut : 1'b1;

    always #50 core_clk = ~core_clk;

    tws_ctrl uut (.core_clk(core_clk), .reset(reset), .clkEn(1'b1),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .sckPinIn(sckWire), .sckPinOut(sckPinOut), .sckPinOe(sckPinOe),
        .soutPinIn(soutWire), .soutPinOut(soutPinOut),
        .soutPinOe(soutPinOe), .sinPinIn(sinWire), .sinPinOut(sinPinOut),
        .sinPinOe(sinPinOe), .irq(irq));

    tws_partner peer (.sckWire(sckWire), .soutWire(soutWire),
        .sckOut(pSck), .sckOe(pSckOe), .sinOut(pSin), .arm(arm),
        .drvClk(drvClk), .txByte(pTx), .rxByte(rxByte), .riseCnt(riseCnt));

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string w, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask

    // Entered just after a rising edge; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input string w);
        bus(1'b0, a, 32'h0);
        chk(w, e, rd);
    endtask

    task automatic waitRise(input int k);
        for (int n = 0; n < 3000 && riseCnt < k; n++) @(posedge core_clk);
    endtask

    task automatic start(input logic [1:0] sel, input logic [7:0] d, p);
        wr(`TWS_ADDR_DATA, {24'h000000, d});
        pTx <= p;
        drvClk <= (sel == 2'b00);
        ctl = ST | SO | ({30'h0, sel} << `TWS_CTRL_CLKLO)
            | ((sel != 2'b00) ? CK : 32'h0);
        wr(`TWS_ADDR_CTRL, ctl);
        arm <= 1'b1;
        @(posedge core_clk);
        arm <= 1'b0;
    endtask

    task automatic finishXfer(input logic [7:0] d, p, input logic rx,
                              input string w);
        for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge core_clk);
        repeat (4) @(posedge core_clk);
        if (rx) chk({w, " rx"}, {24'h0, d}, {24'h0, rxByte});
        chk({w, " clocks"}, 32'h8, riseCnt);
        if (ctl[2:1] != 2'b00) chk("sck idle", 32'h1, {31'h0, sckPinOut});
        bus(1'b0, `TWS_ADDR_PINS, 32'h0);
        chk({w, " counter"}, 32'h0, {28'h0, rd[7:4]});
        rc(`TWS_ADDR_CTRL, ctl & ~ST, {w, " ctrl"});
        rc(`TWS_ADDR_STAT, 32'h1, {w, " stat"});
        rc(`TWS_ADDR_STAT, 32'h0, {w, " stat clr"});
        chk({w, " irq clr"}, 32'h0, {31'h0, irq});
        rc(`TWS_ADDR_DATA, {24'h0, p}, {w, " data"});
        $display("test %s done", w);
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rc(`TWS_ADDR_CTRL, 32'h0, "ctrl rst");
        chk("resp okay", 32'h0, {31'h0, hresp});
        rc(`TWS_ADDR_DATA, {24'h0, `TWS_SHIFT_RST}, "data rst");
        rc(`TWS_ADDR_STAT, 32'h0, "stat rst");
        rc(`TWS_ADDR_MASK, 32'h0, "mask rst");
        wr(8'h20, 32'hFFFF_FFFF);
        rc(8'h20, `TWS_RD_ZERO, "unmapped");
        $display("test reset done");
        // Slave first with the interrupt masked, then every master rate
        for (int s = 0; s < 4; s++) begin
            start(s[1:0], 8'h96 ^ s[7:0], 8'h69 + s[7:0]);
            if (s == 0) begin
                repeat (200) @(posedge core_clk);
                chk("irq masked", 32'h0, {31'h0, irq});
                wr(`TWS_ADDR_MASK, 32'h1);
                repeat (3) @(posedge core_clk);
                chk("irq unmasked", 32'h1, {31'h0, irq});
            end
            finishXfer(8'h96 ^ s[7:0], 8'h69 + s[7:0], 1'b1, "xfer");
        end
        start(2'b01, 8'hC3, 8'h5A);
        waitRise(3);
        wr(`TWS_ADDR_CTRL, ctl);
        finishXfer(8'hC3, 8'h5A, 1'b1, "restart");
        start(2'b11, 8'hF0, 8'h0F);
        waitRise(3);
        wr(`TWS_ADDR_CTRL, ctl & ~ST);
        bus(1'b0, `TWS_ADDR_PINS, 32'h0);
        chk("forced counter", 32'h0, {28'h0, rd[7:4]});
        repeat (600) @(posedge core_clk);
        chk("forced frozen", 32'h3, riseCnt);
        chk("forced sck", 32'h1, {31'h0, sckPinOut});
        rc(`TWS_ADDR_STAT, 32'h0, "forced stat");
        $display("test forced wait done");
        start(2'b11, 8'h00, 8'hFF);
        waitRise(2);
        wr(`TWS_ADDR_DATA, 32'h80);
        repeat (2) @(posedge core_clk);
        chk("hot msb", 32'h1, {31'h0, soutPinOut});
        waitRise(3);
        @(negedge sckWire);
        repeat (2) @(posedge core_clk);
        wr(`TWS_ADDR_DATA, 32'h00);
        finishXfer(8'h00, 8'h3F, 1'b0, "hot write");
        start(2'b11, 8'h55, 8'h00);
        waitRise(4);
        rc(`TWS_ADDR_DATA, {24'h0, `TWS_LOST_VAL}, "hot read");
        finishXfer(8'h00, 8'hF0, 1'b0, "hot read");
        wr(`TWS_ADDR_CTRL, DIRS | GP);
        repeat (2) @(posedge core_clk);
        chk("gp high", 32'h7, {29'h0, sckPinOut, soutPinOut, sinPinOut});
        chk("gp oe", 32'h7, {29'h0, sckPinOe, soutPinOe, sinPinOe});
        wr(`TWS_ADDR_CTRL, DIRS);
        repeat (2) @(posedge core_clk);
        chk("gp low", 32'h0, {29'h0, sckPinOut, soutPinOut, sinPinOut});
        $display("test port mode done");
        conclude();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        conclude();
    end
endmodule

/* test/tws_partner.sv */
// Far-side serial device: slave to our clock, or master of its own
// Assumes the bench resolves pin levels and pulses arm once per frame
module tws_partner (
    // Pins
    input  wire logic       sckWire,
    input  wire logic       soutWire,
    output logic            sckOut,
    output logic            sckOe,
    output logic            sinOut,
    // Bench control
    input  wire logic       arm,
    input  wire logic       drvClk,
    input  wire logic [7:0] txByte,
    output logic      [7:0] rxByte,
    output int              riseCnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh;
    logic       live;

    initial begin
        {sckOe, sinOut, live, sh, rxByte} = '0;
        sckOut = 1'b1;
        riseCnt = 0;
    end

    // Long low phase: the block needs time to resync and update its out pin
    always @(posedge arm) begin
        sh = txByte;
        sinOut = txByte[7];
        riseCnt = 0;
        live = 1'b1;
        if (drvClk) begin
            // Keep pin edges off the core clock edges
            #20;
            sckOe = 1'b1;
            repeat (8) begin
                sckOut = 1'b0;
                #600;
                sckOut = 1'b1;
                #200;
            end
            sckOe = 1'b0;
        end
    end

    always @(negedge sckWire) if (live) sinOut = sh[7];

    // Rises are counted even outside frames, so extra clocks show up
    always @(posedge sckWire) begin
        riseCnt = riseCnt + 1;
        if (live) begin
            rxByte = {rxByte[6:0], soutWire};
            sh = sh << 1;
            if (riseCnt == 8) begin
                live = 1'b0;
                // Released data flips only after the block's sampling point
                fork
                    #330 sinOut = ~sinOut;
                join_none
            end
        end
    end
endmodule
